// file: src/arf_params.svh
/*
 * Constants of the ADC result formatter: register offsets, field positions,
 * reset values and the bus address width.
 * Assumes it is included by its bare name from every file that needs it.
 */
`ifndef ARF_PARAMS_SVH
`define ARF_PARAMS_SVH

// Bus address width in bits.
`define ARF_ADDR_W      8
// Byte offsets of the three registers.
`define ARF_OFF_CTRL    8'h00
`define ARF_OFF_RESH    8'h04
`define ARF_OFF_RESL    8'h08
// Field positions in the control register.
`define ARF_CTRL_EN     0
`define ARF_CTRL_GO     1
`define ARF_CTRL_FMT    7
// Reset value of the control byte.
`define ARF_CTRL_RST    8'h00
// Width of the conversion result.
`define ARF_RES_W       10

`endif

// file: src/arf_pkg.sv
/*
 * Types shared by the ADC result formatter files.
 * Assumes arf_params.svh is available on the include path.
 */
package arf_pkg;
    // Justification of the result in the two result registers.
    typedef enum logic {
        ARF_FMT_LEFT  = 1'b0,
        ARF_FMT_RIGHT = 1'b1
    } arf_fmt_t;

    // AXI response codes.
    typedef enum logic [1:0] {
        ARF_RESP_OKAY   = 2'h0,
        ARF_RESP_SLVERR = 2'h2
    } arf_resp_t;
endpackage

// file: src/arf_fmt.sv
/*
 * Result justifier: spreads a 10-bit conversion result over a high and a
 * low byte, left or right justified, with the unused bits forced to zero.
 * Assumes the caller registers the two bytes; the module is pure logic.
 */
`timescale 1ns/1ps
`default_nettype none
module arf_fmt
    import arf_pkg::*;
(
    input  wire logic [9:0]        value,
    input  wire arf_pkg::arf_fmt_t fmt,
    output logic [7:0]             res_hi,
    output logic [7:0]             res_lo
);
    // Places the result bits according to the selected justification.
    always_comb begin
        if (fmt == ARF_FMT_LEFT) begin
            res_hi = value[9:2];
            res_lo = {value[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, value[9:8]};
            res_lo = value[7:0];
        end
    end
endmodule
`default_nettype wire

// file: src/arf_axil.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * issues one write strobe and one read strobe to the register file, and
 * returns responses from registers.
 * Assumes one clock, synchronous active-low reset, and a register file that
 * answers reads and address checks combinationally in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module arf_axil
    import arf_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               wr_go,
    output logic [AW-1:0]      wr_addr,
    output logic [31:0]        wr_data,
    output logic [3:0]         wr_strb,
    input  wire logic          wr_ok,
    output logic               rd_go,
    output logic [AW-1:0]      rd_addr,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_ok
);
    logic          aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic          awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
    logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0]   wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0]    wstrb_q, wstrb_d;

    // The write executes once both halves are held and no response waits.
    assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_go   = s_axi_arvalid & arrdy_q;
    assign rd_addr = s_axi_araddr;

    // Next state of both channels; ready flags are precomputed into flops.
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && awrdy_q) begin
            aw_full_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_q) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_ok ? ARF_RESP_OKAY : ARF_RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_ok ? rd_data : 32'h0000_0000;
            rresp_d  = rd_ok ? ARF_RESP_OKAY : ARF_RESP_SLVERR;
        end
        awrdy_d = ~aw_full_d & ~bvalid_d;
        wrdy_d  = ~w_full_d & ~bvalid_d;
        arrdy_d = ~rvalid_d;
    end

    // Registers the channel state.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awrdy_q   <= 1'b0;
            wrdy_q    <= 1'b0;
            arrdy_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            rvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rresp_q   <= 2'h0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awrdy_q   <= awrdy_d;
            wrdy_q    <= wrdy_d;
            arrdy_q   <= arrdy_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            rdata_q   <= rdata_d;
        end
    end

    assign s_axi_awready = awrdy_q;
    assign s_axi_wready  = wrdy_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
endmodule
`default_nettype wire

// file: src/arf_top.sv
/*
 * ADC result formatter: control register with enable, conversion status
 * and format select, plus the two result registers, on AXI4-Lite.
 * Assumes a converter front end on the same clock that takes conv_start
 * and answers with conv_done and conv_value; the software allows the
 * acquisition interval before it starts a conversion.
 */
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arf_params.svh"
module arf_top
    import arf_pkg::*;
#(
    parameter int AW = `ARF_ADDR_W
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               conv_start,
    output logic               conv_enable,
    input  wire logic          conv_done,
    input  wire logic [9:0]    conv_value
);
    logic          wr_go, wr_ok, rd_go, rd_ok;
    logic [AW-1:0] wr_addr, rd_addr;
    logic [31:0]   wr_data, rd_data;
    logic [3:0]    wr_strb;
    logic          en_q, en_d, go_q, go_d, start_q, start_d;
    arf_fmt_t      fmt_q, fmt_d;
    logic [7:0]    res_hi_q, res_hi_d, res_lo_q, res_lo_d;
    logic [7:0]    fmt_hi, fmt_lo;
    logic          load, wr_ctrl, wr_hi, wr_lo, go_set;

    // Bus front end.
    arf_axil #(
        .AW(AW)
    ) u_axil (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_go         (wr_go),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_go         (rd_go),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // Justifies the incoming result with the format selected right now.
    arf_fmt u_fmt (
        .value  (conv_value),
        .fmt    (fmt_q),
        .res_hi (fmt_hi),
        .res_lo (fmt_lo)
    );

    // Address decode; all registers sit in byte lane 0.
    assign wr_ok   = (wr_addr == AW'(`ARF_OFF_CTRL)) || (wr_addr == AW'(`ARF_OFF_RESH))
                     || (wr_addr == AW'(`ARF_OFF_RESL));
    assign rd_ok   = (rd_addr == AW'(`ARF_OFF_CTRL)) || (rd_addr == AW'(`ARF_OFF_RESH))
                     || (rd_addr == AW'(`ARF_OFF_RESL));
    assign wr_ctrl = wr_go && wr_strb[0] && (wr_addr == AW'(`ARF_OFF_CTRL));
    assign wr_hi   = wr_go && wr_strb[0] && (wr_addr == AW'(`ARF_OFF_RESH));
    assign wr_lo   = wr_go && wr_strb[0] && (wr_addr == AW'(`ARF_OFF_RESL));

    // A conversion counts only while one is in progress.
    assign load   = go_q && conv_done;
    assign go_set = wr_ctrl && wr_data[`ARF_CTRL_GO] && wr_data[`ARF_CTRL_EN];

    // Read data multiplexer; unused upper bits read as zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            AW'(`ARF_OFF_CTRL): begin
                rd_data[`ARF_CTRL_EN]  = en_q;
                rd_data[`ARF_CTRL_GO]  = go_q;
                rd_data[`ARF_CTRL_FMT] = fmt_q;
            end
            AW'(`ARF_OFF_RESH): begin
                rd_data[7:0] = res_hi_q;
            end
            AW'(`ARF_OFF_RESL): begin
                rd_data[7:0] = res_lo_q;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Next values of control state. A start written in the same cycle as
    // a completion wins, so a back-to-back restart is not lost.
    always_comb begin
        en_d    = en_q;
        fmt_d   = fmt_q;
        go_d    = go_q;
        start_d = 1'b0;
        if (load) begin
            go_d = 1'b0;
        end
        if (wr_ctrl) begin
            en_d  = wr_data[`ARF_CTRL_EN];
            fmt_d = arf_fmt_t'(wr_data[`ARF_CTRL_FMT]);
            if (!wr_data[`ARF_CTRL_EN] || (!wr_data[`ARF_CTRL_GO] && !load)) begin
                go_d = 1'b0;
            end
        end
        if (go_set) begin
            go_d    = 1'b1;
            start_d = 1'b1;
        end
    end

    // Next values of the result bytes. A completion overrides a software
    // write in the same cycle so that no result is dropped.
    always_comb begin
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        if (wr_hi) begin
            res_hi_d = wr_data[7:0];
        end
        if (wr_lo) begin
            res_lo_d = wr_data[7:0];
        end
        if (load) begin
            res_hi_d = fmt_hi;
            res_lo_d = fmt_lo;
        end
    end

    // Registers control state under the ordinary reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            en_q    <= 1'(`ARF_CTRL_RST >> `ARF_CTRL_EN);
            go_q    <= 1'b0;
            fmt_q   <= ARF_FMT_LEFT;
            start_q <= 1'b0;
        end else begin
            en_q    <= en_d;
            go_q    <= go_d;
            fmt_q   <= fmt_d;
            start_q <= start_d;
        end
    end

    // Result bytes have no reset: power-up value is unknown and an
    // ordinary reset leaves them alone.
    always_ff @(posedge core_clk) begin
        res_hi_q <= res_hi_d;
        res_lo_q <= res_lo_d;
    end

    assign conv_start  = start_q;
    assign conv_enable = en_q;

    // Checks of the formatter, the result registers and the status bit.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_LEFT_HI: assert property (
        load && fmt_q == ARF_FMT_LEFT |=> res_hi_q == $past(conv_value[9:2]))
        else $error("High byte wrong in left format.");

    AST_LEFT_LO: assert property (
        load && fmt_q == ARF_FMT_LEFT |=> res_lo_q[7:6] == $past(conv_value[1:0]))
        else $error("Low byte top bits wrong in left format.");

    AST_RIGHT_HI: assert property (
        load && fmt_q == ARF_FMT_RIGHT |=> res_hi_q[1:0] == $past(conv_value[9:8]))
        else $error("High byte low bits wrong in right format.");

    AST_RIGHT_LO: assert property (
        load && fmt_q == ARF_FMT_RIGHT |=> res_lo_q == $past(conv_value[7:0]))
        else $error("Low byte wrong in right format.");

    AST_ZERO_FILL: assert property (
        load |=> ($past(fmt_q) == ARF_FMT_LEFT) ? (res_lo_q[5:0] == 6'h00)
                                                : (res_hi_q[7:2] == 6'h00))
        else $error("Unused result bits not zero after load.");

    AST_KEEP_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_n && !wr_go && !conv_done |=> res_hi_q === $past(res_hi_q)
                                           && res_lo_q === $past(res_lo_q))
        else $error("Result changed across reset.");

    AST_SW_WRITE: assert property (
        wr_lo && !load |=> res_lo_q == $past(wr_data[7:0]))
        else $error("Software write to low result lost.");

    AST_GO_CLEAR: assert property (
        load && !go_set |=> !go_q ##1 !go_q || $past(go_set))
        else $error("Status bit not cleared on completion.");

    AST_GO_START: assert property (
        go_set |=> go_q && conv_start ##1 !conv_start)
        else $error("Start not issued for one cycle.");

    AST_TOGETHER: assert property (
        !load |=> res_hi_q === $past(res_hi_q) || $past(wr_hi))
        else $error("High result changed without a load or write.");

    // Bus handshake, control and low result byte checks.
    AST_B_BLOCKS_AW: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while a response waits.");

    AST_R_BLOCKS_AR: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("Read accepted while read data waits.");

    AST_B_ONE_BEAT: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response repeated.");

    AST_R_ONE_BEAT: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("Read data repeated.");

    AST_BAD_READ: assert property (
        rd_go && !rd_ok |=> s_axi_rresp == ARF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not refused.");

    AST_BAD_WRITE: assert property (
        wr_go && !wr_ok |=> s_axi_bresp == ARF_RESP_SLVERR)
        else $error("Unmapped write not refused.");

    AST_START_NEEDS_EN: assert property (
        conv_start |-> conv_enable)
        else $error("Start issued while disabled.");

    AST_GO_NEEDS_EN: assert property (
        go_q |-> en_q)
        else $error("Status bit set while disabled.");

    AST_ABORT: assert property (
        wr_ctrl && !wr_data[`ARF_CTRL_GO] && !load |=> !go_q)
        else $error("Status bit not cleared by software.");

    AST_NO_EN_NO_GO: assert property (
        wr_ctrl && !wr_data[`ARF_CTRL_EN] |=> !go_q && !conv_start)
        else $error("Start accepted while disabled.");

    AST_LOW_TOGETHER: assert property (
        !load |=> res_lo_q === $past(res_lo_q) || $past(wr_lo))
        else $error("Low result changed without a load or write.");

    AST_RESET_CTRL: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_n |=> !go_q && !en_q && !conv_start)
        else $error("Control state not cleared by reset.");

    // Coverage of the main scenarios.
    COV_LEFT_LOAD:  cover property (load && fmt_q == ARF_FMT_LEFT);
    COV_RIGHT_LOAD: cover property (load && fmt_q == ARF_FMT_RIGHT);
    COV_RESTART:    cover property (load && go_set);
    COV_BAD_ADDR:   cover property (rd_go && !rd_ok);
    COV_ABORT:      cover property (wr_ctrl && go_q && !wr_data[`ARF_CTRL_GO]);
endmodule
`default_nettype wire

// file: dv/arf_top_tb_top.sv
/*
 * Self-checking bench for the result formatter: bus tasks that note the
 * expected answer, converter stimulus, and a monitor that compares each answer.
 * Assumes arf_pkg is compiled first and arf_params.svh is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "arf_params.svh"
module arf_top_tb_top;
    import arf_pkg::*;

    localparam int ACQ_CYC = 50;  // Assumed acquisition wait in clocks.

    logic        core_clk;
    logic        rst_n;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        conv_start;
    logic        conv_enable;
    logic        conv_done;
    logic [9:0]  conv_value;
    logic [31:0] rq_d[$];
    logic [1:0]  rq_r[$];
    logic [1:0]  wq_r[$];
    logic [15:0] last_e;
    logic [9:0]  v;
    int          start_cnt = 0;
    int          error_cnt = 0;
    int          checks = 0;

    arf_top dut_u (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conv_start(conv_start),
        .conv_enable(conv_enable), .conv_done(conv_done), .conv_value(conv_value)
    );

    // Free-running core clock, 100 ns period.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Shared comparison used by the three result kinds below.
    task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
        cmp_val("rdata", e, g);
    endtask

    task automatic cmp_resp(input string what, input logic [1:0] e, input logic [1:0] g);
        cmp_val(what, {30'h0, e}, {30'h0, g});
    endtask

    task automatic cmp_pin(input string what, input logic e, input logic g);
        cmp_val(what, {31'h0, e}, {31'h0, g});
    endtask

    // Bounded wait ran out: count it and stop.
    task automatic give_up();
        error_cnt++;
        close_out();
    endtask

    // Expected byte pair {high, low} for a result and a justification.
    function automatic logic [15:0] packed_res(input logic f, input logic [9:0] x);
        return f ? {6'h00, x} : {x, 6'h00};
    endfunction

    // One AXI4-Lite write; address and data offered together, each released when taken.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        bit aw_ok;
        bit w_ok;
        bit b_ok;
        wq_r.push_back(er);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok) begin
            @(posedge core_clk);
            n++;
            if (!aw_ok && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                b_ok = 1'b1;
            end
            if (n > 40) give_up();
        end
    endtask

    // One AXI4-Lite read; rready held until the answer is sampled.
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        bit ar_ok;
        bit r_ok;
        rq_d.push_back(ed);
        rq_r.push_back(er);
        ar_ok = 1'b0;
        r_ok = 1'b0;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok) begin
            @(posedge core_clk);
            n++;
            if (!ar_ok && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                ar_ok = 1'b1;
            end
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                r_ok = 1'b1;
            end
            if (n > 40) give_up();
        end
    endtask

    // Takes the oldest note off a queue whenever the bus answers, and compares.
    always @(posedge core_clk) begin
        if (rst_n === 1'b1 && s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            if (wq_r.size() == 0) give_up();
            cmp_resp("bresp", wq_r.pop_front(), s_axi_bresp);
        end
        if (rst_n === 1'b1 && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            if (rq_d.size() == 0) give_up();
            cmp_data(rq_d.pop_front(), s_axi_rdata);
            cmp_resp("rresp", rq_r.pop_front(), s_axi_rresp);
        end
    end

    // Counts start pulses sent towards the converter.
    always @(posedge core_clk) begin
        if (conv_start === 1'b1) start_cnt <= start_cnt + 1;
    end

    // One full conversion, then a stray done pulse that must be ignored.
    task automatic convert(input logic f, input logic [9:0] x);
        int n;
        int c0;
        logic [15:0] e;
        e = packed_res(f, x);
        n = 0;
        repeat (ACQ_CYC) @(posedge core_clk);
        c0 = start_cnt;
        bus_wr(`ARF_OFF_CTRL, {24'h0, f, 5'h00, 2'h3}, 4'hF, ARF_RESP_OKAY);
        while (start_cnt == c0) begin
            @(posedge core_clk);
            n++;
            if (n > 20) give_up();
        end
        cmp_pin("conv_enable", 1'b1, conv_enable);
        bus_rd(`ARF_OFF_CTRL, {24'h0, f, 5'h00, 2'h3}, ARF_RESP_OKAY);
        repeat ($urandom_range(12, 1)) @(posedge core_clk);
        conv_done <= 1'b1;
        conv_value <= x;
        @(posedge core_clk);
        conv_done <= 1'b0;
        conv_value <= ~x;
        bus_rd(`ARF_OFF_CTRL, {24'h0, f, 5'h00, 2'h1}, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESH, {24'h0, e[15:8]}, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESL, {24'h0, e[7:0]}, ARF_RESP_OKAY);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        bus_rd(`ARF_OFF_RESH, {24'h0, e[15:8]}, ARF_RESP_OKAY);
        last_e = e;
    endtask

    // Main sequence: reset, register access, conversions, mid-run reset.
    initial begin
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        {conv_done, conv_value} = '0;
        void'($urandom(50256));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        bus_rd(`ARF_OFF_CTRL, 32'h0000_0000, ARF_RESP_OKAY);
        cmp_pin("conv_enable", 1'b0, conv_enable);
        bus_wr(`ARF_OFF_RESH, 32'hFFFF_FF5A, 4'hF, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESH, 32'h0000_005A, ARF_RESP_OKAY);
        bus_wr(`ARF_OFF_RESL, 32'h0000_00C3, 4'hF, ARF_RESP_OKAY);
        bus_wr(`ARF_OFF_RESL, 32'h0000_0011, 4'hE, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESL, 32'h0000_00C3, ARF_RESP_OKAY);
        bus_wr(8'h0C, 32'h0000_00FF, 4'hF, ARF_RESP_SLVERR);
        bus_rd(8'h0C, 32'h0000_0000, ARF_RESP_SLVERR);
        for (int i = 0; i < 16; i++) begin
            case (i)
                0: v = 10'h000;
                1: v = 10'h3FF;
                2: v = 10'h2AA;
                3: v = 10'h155;
                default: v = 10'($urandom_range(1023, 0));
            endcase
            convert(i[0], v);
        end
        bus_wr(`ARF_OFF_CTRL, 32'h0000_0002, 4'hF, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_CTRL, 32'h0000_0000, ARF_RESP_OKAY);
        bus_wr(`ARF_OFF_CTRL, 32'h0000_0003, 4'hF, ARF_RESP_OKAY);
        bus_wr(`ARF_OFF_CTRL, 32'h0000_0001, 4'hF, ARF_RESP_OKAY);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        bus_rd(`ARF_OFF_CTRL, 32'h0000_0001, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESL, {24'h0, last_e[7:0]}, ARF_RESP_OKAY);
        cmp_val("start_cnt", 32'h0000_0011, start_cnt);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        bus_rd(`ARF_OFF_CTRL, 32'h0000_0000, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESH, {24'h0, last_e[15:8]}, ARF_RESP_OKAY);
        bus_rd(`ARF_OFF_RESL, {24'h0, last_e[7:0]}, ARF_RESP_OKAY);
        cmp_pin("conv_enable", 1'b0, conv_enable);
        repeat (2) @(posedge core_clk);
        close_out();
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge core_clk);
        give_up();
    end
endmodule
`default_nettype wire
